// file: srpd_consts.vh
`ifndef SRPD_CONSTS_VH
`define SRPD_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SRPD_ADDR_DIVIDER    8'h18
`define SRPD_ADDR_POWER      8'h19
`define SRPD_ADDR_COUNT      8'h1A
`define SRPD_ADDR_DELAY      8'h1B
`define SRPD_ADDR_SOURCE     8'h1C
`define SRPD_ADDR_MISC       8'h1F
`define SRPD_ADDR_TRIGGER    8'h70

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SRPD_RST_DIVIDER     8'h00
`define SRPD_RST_POWER       8'h44
`define SRPD_RST_COUNT       8'h02
`define SRPD_RST_DELAY       8'h00
`define SRPD_RST_SOURCE      8'h00
`define SRPD_RST_MISC        8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SRPD_BIT_POWER_DOWN  7
`define SRPD_BIT_BIAS_STYLE  6
`define SRPD_BIT_INPUT_SEL   2
`define SRPD_BIT_GEN_SOURCE  1
`define SRPD_BIT_CONT_MODE   0
`define SRPD_BIT_TRIGGER     7

// Aux output change unlock pattern
`define SRPD_UNLOCK_CODE     8'h4B

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRPD_DELAY_STEP_PS   509
`define SRPD_HALF_W          13

`endif

// file: srpd_divider.v
`timescale 1ns/1ps
`default_nettype none
`include "srpd_consts.vh"

module srpd_divider (
  input wire mclk_in,
  input wire resetn_in,
  input wire enable_in,
  input wire [7:0] chain_code_in,
  output reg tick_out
);

  // ----------------------------------------
  // Stage decode
  // ----------------------------------------
  function [2:0] srpd_two_bit_stage;
    input [1:0] code;
    begin
      srpd_two_bit_stage = {1'b0, code} + 3'd2;
    end
  endfunction

  wire [4:0] stage_top = 5'd2 << chain_code_in[7:6];
  wire [2:0] stage_54 = srpd_two_bit_stage(chain_code_in[5:4]);
  wire [2:0] stage_3 = chain_code_in[3] ? 3'd4 : 3'd2;
  wire [2:0] stage_2 = chain_code_in[2] ? 3'd4 : 3'd2;
  wire [2:0] stage_10 = srpd_two_bit_stage(chain_code_in[1:0]);

  localparam [`SRPD_HALF_W-1:0] HALF_ONE = {{(`SRPD_HALF_W-1){1'b0}}, 1'b1};

  // Half period of the output; the fixed factor two gives the full period
  wire [`SRPD_HALF_W-1:0] half_period =
    {{(`SRPD_HALF_W-5){1'b0}}, stage_top} *
    {{(`SRPD_HALF_W-3){1'b0}}, stage_54} *
    {{(`SRPD_HALF_W-3){1'b0}}, stage_3} *
    {{(`SRPD_HALF_W-3){1'b0}}, stage_2} *
    {{(`SRPD_HALF_W-3){1'b0}}, stage_10};

  reg [`SRPD_HALF_W-1:0] count;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= {`SRPD_HALF_W{1'b0}};
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      count <= {`SRPD_HALF_W{1'b0}};
      tick_out <= 1'b0;
    end else if (count >= half_period - HALF_ONE) begin
      count <= {`SRPD_HALF_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      count <= count + HALF_ONE;
      tick_out <= 1'b0;
    end
  end

endmodule // srpd_divider
`default_nettype wire

// file: srpd_sysref_ctrl.v
`timescale 1ns/1ps
`default_nettype none
`include "srpd_consts.vh"

module srpd_sysref_ctrl (
  input wire mclk_in,
  input wire resetn_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [7:0] reg_rdata_out,
  input wire external_sysref_pin_in,
  input wire diff_sysref_in,
  input wire output_bias_force_in,
  output reg sysref_output_n_out,
  output reg sysref_crosspoint_out,
  output reg [7:0] sysref_delay_code_out,
  output wire [5:0] align_divider_out,
  output wire aux_output_change_unlock_out,
  output wire lock_pin_pll_mask_out,
  output wire four_wire_select_out,
  output wire status_pin_voltage_select_out,
  output wire serial_pin_voltage_select_out,
  output wire sysref_power_down_out
);

  localparam ST_IDLE = 2'd0;
  localparam ST_WAIT = 2'd1;
  localparam ST_RUN = 2'd2;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [7:0] sysref_divider_ctrl;
  reg [7:0] sysref_power_bias_align;
  reg [7:0] sysref_pulse_count;
  reg [7:0] sysref_global_delay;
  reg [7:0] sysref_source_mode;
  reg [7:0] lock_interface_misc_ctrl;
  reg pulse_trigger_bit;

  wire sysref_power_down = sysref_power_bias_align[`SRPD_BIT_POWER_DOWN];
  wire bias_style = sysref_power_bias_align[`SRPD_BIT_BIAS_STYLE];
  wire sysref_input_choice = sysref_source_mode[`SRPD_BIT_INPUT_SEL];
  wire generation_source_select = sysref_source_mode[`SRPD_BIT_GEN_SOURCE];
  wire pulse_continuous_mode = sysref_source_mode[`SRPD_BIT_CONT_MODE];
  wire [7:0] pulse_burst_count = sysref_pulse_count;

  wire wr_trigger = reg_wr_in && (reg_addr_in == `SRPD_ADDR_TRIGGER);
  wire trig_set = wr_trigger && reg_wdata_in[`SRPD_BIT_TRIGGER];
  wire trig_clr = wr_trigger && !reg_wdata_in[`SRPD_BIT_TRIGGER];

  reg [1:0] state;
  reg [1:0] next_state;
  reg [7:0] remaining;
  reg phase;
  wire tick;
  reg burst_done;

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sysref_divider_ctrl <= `SRPD_RST_DIVIDER;
      sysref_power_bias_align <= `SRPD_RST_POWER;
      sysref_pulse_count <= `SRPD_RST_COUNT;
      sysref_global_delay <= `SRPD_RST_DELAY;
      sysref_source_mode <= `SRPD_RST_SOURCE;
      lock_interface_misc_ctrl <= `SRPD_RST_MISC;
    end else if (reg_wr_in) begin
      case (reg_addr_in)
        `SRPD_ADDR_DIVIDER: sysref_divider_ctrl <= reg_wdata_in;
        `SRPD_ADDR_POWER: sysref_power_bias_align <= reg_wdata_in;
        `SRPD_ADDR_COUNT: sysref_pulse_count <= reg_wdata_in;
        `SRPD_ADDR_DELAY: sysref_global_delay <= reg_wdata_in;
        `SRPD_ADDR_SOURCE: sysref_source_mode <= reg_wdata_in;
        `SRPD_ADDR_MISC: lock_interface_misc_ctrl <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  // Trigger bit reads 1 while a software burst is pending or running
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pulse_trigger_bit <= 1'b0;
    end else if (sysref_power_down) begin
      pulse_trigger_bit <= 1'b0;
    end else if (trig_set) begin
      pulse_trigger_bit <= 1'b1;
    end else if (trig_clr || (burst_done && !pulse_continuous_mode)) begin
      pulse_trigger_bit <= 1'b0;
    end
  end

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `SRPD_ADDR_DIVIDER: reg_rdata_out <= sysref_divider_ctrl;
        `SRPD_ADDR_POWER: reg_rdata_out <= sysref_power_bias_align;
        `SRPD_ADDR_COUNT: reg_rdata_out <= sysref_pulse_count;
        `SRPD_ADDR_DELAY: reg_rdata_out <= sysref_global_delay;
        `SRPD_ADDR_SOURCE: reg_rdata_out <= sysref_source_mode;
        `SRPD_ADDR_MISC: reg_rdata_out <= lock_interface_misc_ctrl;
        `SRPD_ADDR_TRIGGER: reg_rdata_out <= {pulse_trigger_bit, 7'h00};
        default: reg_rdata_out <= 8'h00;
      endcase
    end
  end

  assign align_divider_out = sysref_power_bias_align[5:0];
  assign aux_output_change_unlock_out =
    ({sysref_source_mode[7:4], lock_interface_misc_ctrl[3:0]} == `SRPD_UNLOCK_CODE);
  assign lock_pin_pll_mask_out = lock_interface_misc_ctrl[7];
  assign four_wire_select_out = lock_interface_misc_ctrl[6];
  assign status_pin_voltage_select_out = lock_interface_misc_ctrl[5];
  assign serial_pin_voltage_select_out = lock_interface_misc_ctrl[4];
  assign sysref_power_down_out = sysref_power_down;

  // ----------------------------------------
  // External input synchronisers
  // ----------------------------------------
  reg [1:0] ext_sync;
  reg [1:0] diff_sync;
  reg [1:0] bias_sync;
  reg ext_prev;

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_sync <= 2'b00;
      diff_sync <= 2'b00;
      bias_sync <= 2'b00;
    end else begin
      ext_sync <= {ext_sync[0], external_sysref_pin_in};
      diff_sync <= {diff_sync[0], diff_sysref_in};
      bias_sync <= {bias_sync[0], output_bias_force_in};
    end
  end

  wire ext_level = sysref_input_choice ? diff_sync[1] : ext_sync[1];

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_level;
    end
  end

  wire ext_rise = ext_level && !ext_prev;

  // ----------------------------------------
  // Divider chain and pulse sequencer
  // ----------------------------------------
  srpd_divider u_divider (
    .mclk_in(mclk_in),
    .resetn_in(resetn_in),
    .enable_in(!sysref_power_down),
    .chain_code_in(sysref_divider_ctrl),
    .tick_out(tick)
  );

  // Start and keep-running requests from the chosen source
  wire start_req = generation_source_select ?
    (pulse_continuous_mode ? ext_level : ext_rise) : trig_set;
  wire keep_run = generation_source_select ? ext_level : pulse_trigger_bit;
  wire rise_tick = tick && !phase;
  wire fall_tick = tick && phase;

  always @* begin
    next_state = state;
    burst_done = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_req) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!pulse_continuous_mode && (pulse_burst_count == 8'h00)) begin
          next_state = ST_IDLE;
          burst_done = 1'b1;
        end else if (rise_tick) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (fall_tick) begin
          if (pulse_continuous_mode ? !keep_run : (remaining == 8'h01)) begin
            next_state = ST_IDLE;
            burst_done = 1'b1;
          end
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      remaining <= 8'h00;
      phase <= 1'b0;
    end else if (sysref_power_down) begin
      state <= ST_IDLE;
      remaining <= 8'h00;
      phase <= 1'b0;
    end else begin
      state <= next_state;
      if (tick) begin
        phase <= !phase;
      end
      if (state == ST_WAIT && rise_tick) begin
        remaining <= pulse_burst_count;
      end else if (state == ST_RUN && fall_tick) begin
        remaining <= remaining - 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Output stage
  // ----------------------------------------
  wire pulsing = (state == ST_RUN) && !bias_sync[1];

  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sysref_output_n_out <= 1'b0;
      sysref_crosspoint_out <= 1'b1;
      sysref_delay_code_out <= 8'h00;
    end else begin
      sysref_output_n_out <= pulsing && phase;
      sysref_crosspoint_out <= !pulsing && bias_style;
      sysref_delay_code_out <= sysref_global_delay;
    end
  end

endmodule // srpd_sysref_ctrl
`default_nettype wire

// file: srpd_sysref_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "srpd_consts.vh"
module srpd_sysref_ctrl_props (
  input wire logic mclk_in,
  input wire logic resetn_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic output_bias_force_in,
  input wire logic sysref_output_n_out,
  input wire logic sysref_crosspoint_out,
  input wire logic [7:0] sysref_delay_code_out,
  input wire logic [5:0] align_divider_out,
  input wire logic sysref_power_down_out
);
  logic [15:0] hi_cnt;
  wire wr_pwr = reg_wr_in && reg_addr_in == `SRPD_ADDR_POWER;
  // Length of the current high phase
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) hi_cnt <= 16'h0000;
    else hi_cnt <= sysref_output_n_out ? hi_cnt + 16'h0001 : 16'h0000;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  AST_DELAY: assert property (reg_wr_in && reg_addr_in == `SRPD_ADDR_DELAY
    |-> ##2 sysref_delay_code_out == $past(reg_wdata_in, 2)) else $error("delay code");
  AST_ALIGN: assert property (wr_pwr
    |=> align_divider_out == $past(reg_wdata_in[5:0])) else $error("align divider");
  AST_PD_BIT: assert property (wr_pwr
    |=> sysref_power_down_out == $past(reg_wdata_in[7])) else $error("power down bit");
  AST_PD_IDLE: assert property (sysref_power_down_out [*3]
    |-> !sysref_output_n_out) else $error("output active in power down");
  AST_FORCE: assert property (output_bias_force_in [*4]
    |-> !sysref_output_n_out) else $error("output active while forced");
  AST_DRIVE: assert property (sysref_output_n_out
    |-> !sysref_crosspoint_out) else $error("biased while pulsing");
  AST_MIN_HIGH: assert property ($fell(sysref_output_n_out) && !output_bias_force_in
    |-> hi_cnt >= 16'h0020) else $error("high phase too short");
  AST_MIN_LOW: assert property ($fell(sysref_output_n_out)
    |-> !sysref_output_n_out [*8]) else $error("low phase too short");
  cover property ($rose(sysref_output_n_out));
  cover property (wr_pwr && sysref_power_down_out);
  cover property (output_bias_force_in && $fell(sysref_output_n_out));
endmodule // srpd_sysref_ctrl_props
`default_nettype wire

// file: srpd_converter_model.sv
`timescale 1ns/1ps
`default_nettype none
module srpd_converter_model (
  input wire logic mclk_in,
  input wire logic clear_in,
  input wire logic sysref_in,
  output var logic [15:0] pulse_count_out,
  output var logic [15:0] high_len_out
);
  logic [15:0] run;
  logic prev;
  // Counts received pulses and keeps the width of the last one
  always @(posedge mclk_in) begin
    prev <= sysref_in;
    run <= sysref_in ? run + 16'h0001 : 16'h0000;
    if (clear_in) pulse_count_out <= 16'h0000;
    else if (sysref_in && !prev) pulse_count_out <= pulse_count_out + 16'h0001;
    if (!sysref_in && prev) high_len_out <= run;
  end
endmodule // srpd_converter_model
`default_nettype wire

// file: test_srpd_sysref_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "srpd_consts.vh"
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin n_fail++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module test_srpd_sysref_ctrl;
  logic mclk_in = 0, resetn_in = 0, wr = 0, rd = 0, ext = 0, dif = 0, frc = 0, clr = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, dly, v;
  logic [5:0] algn;
  logic so, cp, pd, unl, lpm, fws, ssv, psv;
  logic [15:0] pc, hl;
  logic [31:0] seed = 32'h1b9a_f762;
  int n_fail = 0, checked = 0, cyc = 0, i, h;
  logic [7:0] ra [7] = '{8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1F, 8'h20};
  logic [7:0] re [7] = '{`SRPD_RST_DIVIDER, `SRPD_RST_POWER, `SRPD_RST_COUNT,
    `SRPD_RST_DELAY, `SRPD_RST_SOURCE, `SRPD_RST_MISC, 8'h00};
  logic [7:0] cd [5] = '{8'h00, 8'h55, 8'h33, 8'hAA, 8'hFF};
  srpd_sysref_ctrl dut_u (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .external_sysref_pin_in(ext), .diff_sysref_in(dif), .output_bias_force_in(frc),
    .sysref_output_n_out(so), .sysref_crosspoint_out(cp), .sysref_delay_code_out(dly),
    .align_divider_out(algn), .aux_output_change_unlock_out(unl),
    .lock_pin_pll_mask_out(lpm), .four_wire_select_out(fws),
    .status_pin_voltage_select_out(ssv), .serial_pin_voltage_select_out(psv),
    .sysref_power_down_out(pd));
  srpd_converter_model conv_u (.mclk_in(mclk_in), .clear_in(clr), .sysref_in(so),
    .pulse_count_out(pc), .high_len_out(hl));
  initial forever #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 99000) begin
      n_fail++;
      final_report;
    end
  end
  task final_report;
    $display("mismatches %0d checks %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  function [31:0] nxt(input [31:0] x);
    nxt = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function int half(input [7:0] c);
    half = (2 << c[7:6]) * (2 + c[5:4]) * (c[3] ? 4 : 2) * (c[2] ? 4 : 2) * (2 + c[1:0]);
  endfunction
  task wr_reg(input [7:0] a, d);
    @(negedge mclk_in) {addr, wdata, wr} = {a, d, 1'b1};
    @(negedge mclk_in) wr = 0;
    @(negedge mclk_in);
  endtask
  task rd_reg(input [7:0] a, output [7:0] d);
    @(negedge mclk_in) {addr, rd} = {a, 1'b1};
    @(negedge mclk_in) rd = 0;
    d = rdata;
  endtask
  task wait_h(input int k);
    repeat (k * h) @(negedge mclk_in);
  endtask
  task clear;
    clr = 1;
    @(negedge mclk_in) clr = 0;
  endtask
  task burst(input [7:0] code, cnt, input int src);
    h = half(code);
    wr_reg(`SRPD_ADDR_DIVIDER, code);
    wr_reg(`SRPD_ADDR_COUNT, cnt);
    wr_reg(`SRPD_ADDR_SOURCE, src == 0 ? 8'h00 : src == 1 ? 8'h02 : 8'h06);
    clear;
    if (src == 0) wr_reg(`SRPD_ADDR_TRIGGER, 8'h80);
    else if (src == 1) ext = 1;
    else dif = 1;
    for (i = 0; i < 60000 && !(pc == cnt && !so); i++) @(negedge mclk_in);
    wait_h(4);
    `CHK("pulse count", {8'h00, cnt}, pc)
    if (cnt > 0) `CHK("high width", h[15:0], hl)
    {ext, dif} = 2'b00;
    rd_reg(`SRPD_ADDR_TRIGGER, v);
    `CHK("trigger clear", 8'h00, v)
  endtask
  initial begin
    repeat (10) @(negedge mclk_in);
    resetn_in = 1;
    foreach (ra[k]) begin
      rd_reg(ra[k], v);
      `CHK("reset value", re[k], v)
    end
    // Side outputs: all set with the unlock pattern, then a mixed pattern, then clear
    wr_reg(`SRPD_ADDR_SOURCE, 8'h40);
    wr_reg(`SRPD_ADDR_MISC, 8'hFB);
    `CHK("misc outputs set", 5'h1F, {unl, lpm, fws, ssv, psv})
    wr_reg(`SRPD_ADDR_MISC, 8'h5A);
    `CHK("misc outputs mixed", 5'h05, {unl, lpm, fws, ssv, psv})
    wr_reg(`SRPD_ADDR_SOURCE, 8'h00);
    wr_reg(`SRPD_ADDR_MISC, 8'h00);
    `CHK("misc outputs clear", 5'h00, {unl, lpm, fws, ssv, psv})
    for (int k = 0; k < 6; k++) begin
      seed = nxt(seed);
      wr_reg(`SRPD_ADDR_DELAY, seed[7:0]);
      `CHK("delay code", seed[7:0], dly)
    end
    // Align 12 is the common multiple of channel ratios 3 and 4
    wr_reg(`SRPD_ADDR_POWER, 8'h4C);
    `CHK("align", 6'h0C, algn)
    `CHK("idle bias high", 1'b1, cp)
    wr_reg(`SRPD_ADDR_POWER, 8'h0C);
    `CHK("idle bias low", 1'b0, cp)
    wr_reg(`SRPD_ADDR_POWER, 8'h4C);
    for (int k = 0; k < 5; k++) begin
      seed = nxt(seed);
      burst(cd[k], k == 4 ? 8'h01 : {6'h00, seed[1:0]}, 0);
    end
    burst(8'h00, 8'h00, 0);
    burst(8'h00, 8'h02, 1);
    burst(8'h00, 8'h03, 2);
    wr_reg(`SRPD_ADDR_SOURCE, 8'h01);
    clear;
    wr_reg(`SRPD_ADDR_TRIGGER, 8'h80);
    for (i = 0; i < 4000 && pc < 3; i++) @(negedge mclk_in);
    `CHK("continuous", 1'b1, pc >= 3)
    frc = 1;
    repeat (8) @(negedge mclk_in);
    v = pc[7:0];
    wr_reg(`SRPD_ADDR_TRIGGER, 8'h00);
    wait_h(4);
    `CHK("forced masks", v, pc[7:0])
    frc = 0;
    wait_h(4);
    `CHK("stopped", v, pc[7:0])
    // Continuous run held by the external pin level
    wr_reg(`SRPD_ADDR_SOURCE, 8'h03);
    clear;
    ext = 1;
    for (i = 0; i < 4000 && pc < 2; i++) @(negedge mclk_in);
    `CHK("ext continuous", 1'b1, pc >= 2)
    ext = 0;
    wait_h(4);
    v = pc[7:0];
    wait_h(4);
    `CHK("ext stopped", v, pc[7:0])
    wr_reg(`SRPD_ADDR_SOURCE, 8'h00);
    wr_reg(`SRPD_ADDR_POWER, 8'hCC);
    `CHK("pd out", 1'b1, pd)
    clear;
    wr_reg(`SRPD_ADDR_TRIGGER, 8'h80);
    wait_h(4);
    `CHK("pd pulses", 16'h0000, pc)
    rd_reg(`SRPD_ADDR_TRIGGER, v);
    `CHK("pd trigger", 8'h00, v)
    wr_reg(`SRPD_ADDR_POWER, 8'h4C);
    `CHK("pd released", 1'b0, pd)
    burst(8'h00, 8'h01, 0);
    final_report;
  end
endmodule // test_srpd_sysref_ctrl
bind srpd_sysref_ctrl srpd_sysref_ctrl_props chk_u (.mclk_in(mclk_in),
  .resetn_in(resetn_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
  .reg_wr_in(reg_wr_in), .output_bias_force_in(output_bias_force_in),
  .sysref_output_n_out(sysref_output_n_out), .sysref_crosspoint_out(sysref_crosspoint_out),
  .sysref_delay_code_out(sysref_delay_code_out), .align_divider_out(align_divider_out),
  .sysref_power_down_out(sysref_power_down_out));
`default_nettype wire
